// file: hdl/hlt_timer.sv
/*
 * Hardware-limit period timer: prescaler, 8-bit count, period compare, postscaler,
 * mode-driven gate/reset/one-shot/monostable control, plain register port.
 * Assumes one clk_sys domain, synchronous rst_n, bus strobes one cycle long.
 */
// Chosen here: the address map and strobed register access.
// Summary of operation
// RULE1 - count per tick; wrap to zero after match
// RULE2 - count/control writes, resets clear prescale, postscale
// RULE3 - source spaces edges six, levels three clocks
// RULE4 - postscale match gives one-tick pulse, clears
// RULE5 - one-shot match clears run, stops at zero
// RULE6 - monostable match stops at zero, run kept
// RULE7 - edge-start modes need fresh edge after rerun
// RULE8 - postscale match 1:1..1:16 sets interrupt flag
// RULE9 - interrupt forwarded only while enable set
// RULE10 - software gate: count while run set
// RULE11 - gate modes count while signal high/low
// RULE12 - edge-reset modes: any, rising, falling edge
// RULE13 - level-reset modes: reset while low/high
// RULE14 - level-reset modes ignore signal while stopped
// RULE15 - level reset; counting resumes two ticks later
// RULE16 - software one-shot runs one period, clears run
// RULE17 - software one-shot pauses and resumes on run
// RULE18 - edge one-shots start on chosen edge
// RULE19 - halted edge one-shot needs new edge
// RULE20 - first edge starts, later edges reset, two-tick resume
// RULE21 - edges ignored until run set; match clears run
// RULE22 - level reset, edge to active level starts
// RULE23 - after run cleared, wait new start edge
// RULE24 - monostable starts on chosen edge, stops at match
// RULE25 - level one-shot counts off reset level, clears run
// RULE26 - reserved modes hold zero, no interrupt
// RULE27 - run bit and signal pass two sync stages; the signal here passes three flops and a filter register
`timescale 1ns/1ps
module hlt_timer
	import hlt_pkg::*;
#(
	parameter int RESTART_TICKS = 2
)(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [hlt_pkg::HLT_ADDR_W-1:0] reg_addr,
	input wire logic [hlt_pkg::HLT_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [hlt_pkg::HLT_DATA_W-1:0] reg_rdata,
	input wire logic ext_reset_signal,
	output logic [7:0] count_value,
	output logic [7:0] period_value,
	output logic postscaled_pulse,
	output logic timer_irq
);
	import hlt_pkg::*;

	if (RESTART_TICKS != int'(HLT_RESTART_TICKS)) begin : g_bad_restart
		$error("restart delay is fixed by the package constant");
	end

	////////////////////////////////////////////////////////////////////////////////
	// external signal synchroniser

	hlt_ers_if ers ();

	hlt_pin_sync u_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pin_in(ext_reset_signal),
		.ers(ers.src)
	);

	////////////////////////////////////////////////////////////////////////////////
	// state and decode

	hlt_state_t s;
	hlt_state_t next_s;
	hlt_stop_t stop_kind;
	logic e;
	logic on_s;
	logic re;
	logic fe;
	logic tick;
	logic match;
	logic run;
	logic start;
	logic hw_rst;
	logic reserved;
	logic wrap;
	logic post_hit;
	logic wr_cnt;
	logic wr_ctl;
	logic [7:0] psc_full;

	assign e = ers.level;
	assign on_s = s.on_d2; // [RULE27]
	assign psc_full = (8'h01 << s.prescale_select) - 8'h01;
	assign tick = (s.psc == psc_full[6:0]);
	assign match = (s.cnt == s.period);
	assign re = s.rise_p | (e & ~s.ers_prev);
	assign fe = s.fall_p | (~e & s.ers_prev);
	assign wr_cnt = reg_wr && (reg_addr == HLT_ADDR_COUNT);
	assign wr_ctl = reg_wr && (reg_addr == HLT_ADDR_CTRL);
	assign post_hit = (s.post == s.postscale_select); // [RULE8]

	always_comb begin
		run = 1'b0;
		start = 1'b0;
		hw_rst = 1'b0;
		reserved = 1'b0;
		stop_kind = HLT_STOP_NONE;
		case (s.mode)
			HLT_M_SW_GATE: run = on_s; // [RULE10]
			HLT_M_GATE_HI: run = on_s & e; // [RULE11]
			HLT_M_GATE_LO: run = on_s & ~e; // [RULE11]
			HLT_M_RST_ANY: begin
				run = on_s;
				hw_rst = on_s & (re | fe); // [RULE12]
			end
			HLT_M_RST_RISE: begin
				run = on_s;
				hw_rst = on_s & re; // [RULE12]
			end
			HLT_M_RST_FALL: begin
				run = on_s;
				hw_rst = on_s & fe; // [RULE12]
			end
			HLT_M_RST_LOW: begin
				run = on_s;
				hw_rst = on_s & ~e; // [RULE13] [RULE14] [RULE15]
			end
			HLT_M_RST_HIGH: begin
				run = on_s;
				hw_rst = on_s & e; // [RULE13] [RULE14] [RULE15]
			end
			HLT_M_OS_SW: begin
				run = on_s; // [RULE16] [RULE17]
				stop_kind = HLT_STOP_ONESHOT;
			end
			HLT_M_OS_RISE, HLT_M_OS_FALL, HLT_M_OS_ANY: begin
				start = (s.mode == HLT_M_OS_RISE) ? re :
					(s.mode == HLT_M_OS_FALL) ? fe : (re | fe); // [RULE18]
				run = on_s & s.armed;
				stop_kind = HLT_STOP_ONESHOT;
			end
			HLT_M_OS_RISE_RST, HLT_M_OS_FALL_RST: begin
				start = (s.mode == HLT_M_OS_RISE_RST) ? re : fe; // [RULE20]
				hw_rst = on_s & s.armed & start; // [RULE20]
				run = on_s & s.armed;
				stop_kind = HLT_STOP_ONESHOT; // [RULE21]
			end
			HLT_M_OS_LOWRST: begin
				hw_rst = on_s & ~e; // [RULE22]
				start = re;
				run = on_s & s.armed & e;
				stop_kind = HLT_STOP_ONESHOT;
			end
			HLT_M_OS_HIGHRST: begin
				hw_rst = on_s & e; // [RULE22]
				start = fe;
				run = on_s & s.armed & ~e;
				stop_kind = HLT_STOP_ONESHOT;
			end
			HLT_M_MS_RISE, HLT_M_MS_FALL, HLT_M_MS_ANY: begin
				start = (s.mode == HLT_M_MS_RISE) ? re :
					(s.mode == HLT_M_MS_FALL) ? fe : (re | fe); // [RULE24]
				run = on_s & s.armed;
				stop_kind = HLT_STOP_MONO;
			end
			HLT_M_LVL_LOW: begin
				hw_rst = on_s & ~e; // [RULE25]
				run = on_s & e;
				stop_kind = HLT_STOP_ONESHOT;
			end
			HLT_M_LVL_HIGH: begin
				hw_rst = on_s & e; // [RULE25]
				run = on_s & ~e;
				stop_kind = HLT_STOP_ONESHOT;
			end
			default: reserved = 1'b1; // [RULE26]
		endcase
	end

	assign wrap = tick && !reserved && !hw_rst && (s.dly == 2'h0) && run && match;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		next_s = s;
		next_s.on_d1 = s.on; // [RULE27]
		next_s.on_d2 = s.on_d1;
		next_s.ers_prev = e;
		next_s.psc = tick ? 7'h00 : s.psc + 7'h01;
		// edges seen while stopped are dropped
		next_s.rise_p = on_s & (s.rise_p | (e & ~s.ers_prev)); // [RULE21]
		next_s.fall_p = on_s & (s.fall_p | (~e & s.ers_prev));
		if (!on_s) begin
			next_s.armed = 1'b0; // [RULE7] [RULE19] [RULE23]
		end
		if (tick) begin
			next_s.rise_p = 1'b0;
			next_s.fall_p = 1'b0;
			next_s.pulse = 1'b0; // [RULE4]
			if (start && on_s && !s.armed) begin
				next_s.armed = 1'b1; // [RULE18] [RULE24]
			end
			if (reserved) begin
				next_s.cnt = HLT_COUNT_RESET; // [RULE26]
			end else if (hw_rst) begin
				next_s.cnt = HLT_COUNT_RESET;
				next_s.psc = 7'h00; // [RULE2]
				next_s.post = 4'h0;
				next_s.dly = HLT_RESTART_TICKS; // [RULE15] [RULE20]
			end else if (s.dly != 2'h0) begin
				next_s.dly = s.dly - 2'h1;
			end else if (run) begin
				if (match) begin
					next_s.cnt = HLT_COUNT_RESET; // [RULE1]
					if (post_hit) begin
						next_s.post = 4'h0;
						next_s.pulse = 1'b1; // [RULE4]
						next_s.flag = 1'b1; // [RULE8]
					end else begin
						next_s.post = s.post + 4'h1;
					end
					if (stop_kind == HLT_STOP_ONESHOT) begin
						next_s.on = 1'b0; // [RULE5] [RULE16]
						next_s.on_d1 = 1'b0;
						next_s.on_d2 = 1'b0;
						next_s.armed = 1'b0;
					end else if (stop_kind == HLT_STOP_MONO) begin
						next_s.armed = 1'b0; // [RULE6]
					end
				end else begin
					next_s.cnt = s.cnt + 8'h01; // [RULE1]
				end
			end
		end
		// register reads see the state before this cycle's writes
		next_s.rdata = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				HLT_ADDR_COUNT: next_s.rdata = s.cnt;
				HLT_ADDR_PERIOD: next_s.rdata = s.period;
				HLT_ADDR_CTRL: next_s.rdata = {s.on, s.prescale_select, s.postscale_select};
				HLT_ADDR_MODE: next_s.rdata = {3'h0, s.mode};
				HLT_ADDR_IRQ: next_s.rdata = {6'h00, s.irq_en, s.flag};
				default: next_s.rdata = 8'h00;
			endcase
		end
		if (reg_wr) begin
			case (reg_addr)
				HLT_ADDR_COUNT: begin
					next_s.cnt = reg_wdata;
					next_s.psc = 7'h00; // [RULE2]
					next_s.post = 4'h0;
				end
				HLT_ADDR_PERIOD: next_s.period = reg_wdata;
				HLT_ADDR_CTRL: begin
					next_s.on = reg_wdata[HLT_CTRL_ON_BIT];
					next_s.prescale_select = reg_wdata[HLT_CTRL_PRESCALE_LSB +: 3];
					next_s.postscale_select = reg_wdata[HLT_CTRL_POSTSCALE_LSB +: 4];
					next_s.psc = 7'h00; // [RULE2]
					next_s.post = 4'h0;
				end
				HLT_ADDR_MODE: next_s.mode = reg_wdata[4:0];
				HLT_ADDR_IRQ: begin
					next_s.irq_en = reg_wdata[HLT_IRQ_EN_BIT];
					// a flag set in this cycle survives the clear
					if (reg_wdata[HLT_IRQ_FLAG_BIT] && !(wrap && post_hit)) begin
						next_s.flag = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= HLT_STATE_RESET; // [RULE2]
		end else begin
			s <= next_s;
		end
	end

	assign reg_rdata = s.rdata;
	assign count_value = s.cnt;
	assign period_value = s.period;
	assign postscaled_pulse = s.pulse;
	assign timer_irq = s.flag & s.irq_en; // [RULE9]

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	property p_wrap_zero; // [RULE1]
		@(posedge clk_sys) disable iff (!rst_n)
		(wrap && !wr_cnt) |=> (s.cnt == 8'h00);
	endproperty
	a_wrap_zero: assert property (p_wrap_zero) else $error("count not zero after period match");

	property p_post_pulse; // [RULE4]
		@(posedge clk_sys) disable iff (!rst_n)
		(wrap && post_hit && !wr_cnt && !wr_ctl) |=> (postscaled_pulse && s.post == 4'h0);
	endproperty
	a_post_pulse: assert property (p_post_pulse) else $error("postscale pulse missing");

	property p_oneshot_stop; // [RULE5]
		@(posedge clk_sys) disable iff (!rst_n)
		(wrap && stop_kind == HLT_STOP_ONESHOT && !reg_wr) |=> (!s.on && s.cnt == 8'h00)
			##1 (s.cnt == 8'h00);
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

	property p_mono_stop; // [RULE6]
		@(posedge clk_sys) disable iff (!rst_n)
		(wrap && stop_kind == HLT_STOP_MONO && !reg_wr) |=> (s.on && !s.armed && s.cnt == 8'h00);
	endproperty
	a_mono_stop: assert property (p_mono_stop) else $error("monostable stop wrong");

	property p_flag_set; // [RULE8]
		@(posedge clk_sys) disable iff (!rst_n)
		(wrap && post_hit) |=> s.flag;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("interrupt flag not set");

	property p_irq_gate; // [RULE9]
		@(posedge clk_sys) disable iff (!rst_n)
		(reg_wr && reg_addr == HLT_ADDR_IRQ && !reg_wdata[HLT_IRQ_EN_BIT]) |=> !timer_irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

	property p_sw_count; // [RULE10]
		@(posedge clk_sys) disable iff (!rst_n)
		(s.mode == HLT_M_SW_GATE && tick && on_s && s.dly == 2'h0 && !match && !reg_wr)
			|=> (s.cnt == $past(s.cnt) + 8'h01);
	endproperty
	a_sw_count: assert property (p_sw_count) else $error("software gate count did not advance");

	property p_level_ignored; // [RULE14]
		@(posedge clk_sys) disable iff (!rst_n)
		((s.mode == HLT_M_RST_LOW || s.mode == HLT_M_RST_HIGH) && !on_s && !wr_cnt)
			|=> $stable(s.cnt);
	endproperty
	a_level_ignored: assert property (p_level_ignored) else $error("stopped count moved");

	property p_reserved_zero; // [RULE26]
		@(posedge clk_sys) disable iff (!rst_n)
		(reserved && tick && !wr_cnt) |=> (s.cnt == 8'h00 && !postscaled_pulse);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved mode counted");

	property p_on_sync; // [RULE27]
		@(posedge clk_sys) disable iff (!rst_n)
		$rose(s.on) |-> !on_s ##1 !on_s;
	endproperty
	a_on_sync: assert property (p_on_sync) else $error("run bit took effect too soon");
endmodule // hlt_timer

// file: hdl/hlt_pkg.sv
/*
 * Shared constants and types for the hardware-limit period timer:
 * register offsets, field positions, reset values, mode codes and the state record.
 * Assumes one 100 MHz system clock and a synchronous active-low reset.
 */
package hlt_pkg;
	localparam int HLT_ADDR_W = 3;
	localparam int HLT_DATA_W = 8;
	localparam logic [2:0] HLT_ADDR_COUNT = 3'h0;
	localparam logic [2:0] HLT_ADDR_PERIOD = 3'h1;
	localparam logic [2:0] HLT_ADDR_CTRL = 3'h2;
	localparam logic [2:0] HLT_ADDR_MODE = 3'h3;
	localparam logic [2:0] HLT_ADDR_IRQ = 3'h4;
	localparam int HLT_CTRL_ON_BIT = 7;
	localparam int HLT_CTRL_PRESCALE_LSB = 4;
	localparam int HLT_CTRL_POSTSCALE_LSB = 0;
	localparam int HLT_IRQ_FLAG_BIT = 0;
	localparam int HLT_IRQ_EN_BIT = 1;
	localparam logic [7:0] HLT_COUNT_RESET = 8'h00;
	localparam logic [7:0] HLT_PERIOD_RESET = 8'hff;
	localparam logic [1:0] HLT_RESTART_TICKS = 2'h2;

	// mode field codes
	localparam logic [4:0] HLT_M_SW_GATE = 5'h00;
	localparam logic [4:0] HLT_M_GATE_HI = 5'h01;
	localparam logic [4:0] HLT_M_GATE_LO = 5'h02;
	localparam logic [4:0] HLT_M_RST_ANY = 5'h03;
	localparam logic [4:0] HLT_M_RST_RISE = 5'h04;
	localparam logic [4:0] HLT_M_RST_FALL = 5'h05;
	localparam logic [4:0] HLT_M_RST_LOW = 5'h06;
	localparam logic [4:0] HLT_M_RST_HIGH = 5'h07;
	localparam logic [4:0] HLT_M_OS_SW = 5'h08;
	localparam logic [4:0] HLT_M_OS_RISE = 5'h09;
	localparam logic [4:0] HLT_M_OS_FALL = 5'h0a;
	localparam logic [4:0] HLT_M_OS_ANY = 5'h0b;
	localparam logic [4:0] HLT_M_OS_RISE_RST = 5'h0c;
	localparam logic [4:0] HLT_M_OS_FALL_RST = 5'h0d;
	localparam logic [4:0] HLT_M_OS_LOWRST = 5'h0e;
	localparam logic [4:0] HLT_M_OS_HIGHRST = 5'h0f;
	localparam logic [4:0] HLT_M_MS_RISE = 5'h11;
	localparam logic [4:0] HLT_M_MS_FALL = 5'h12;
	localparam logic [4:0] HLT_M_MS_ANY = 5'h13;
	localparam logic [4:0] HLT_M_LVL_LOW = 5'h16;
	localparam logic [4:0] HLT_M_LVL_HIGH = 5'h17;

	// stop behaviour at a period match
	typedef enum logic [1:0] {
		HLT_STOP_NONE = 2'b00,
		HLT_STOP_ONESHOT = 2'b01,
		HLT_STOP_MONO = 2'b10
	} hlt_stop_t;

	typedef struct packed {
		logic [7:0] cnt;
		logic [7:0] period;
		logic on;
		logic [2:0] prescale_select;
		logic [3:0] postscale_select;
		logic [4:0] mode;
		logic [6:0] psc;
		logic [3:0] post;
		logic flag;
		logic irq_en;
		logic on_d1;
		logic on_d2;
		logic ers_prev;
		logic rise_p;
		logic fall_p;
		logic armed;
		logic [1:0] dly;
		logic pulse;
		logic [7:0] rdata;
	} hlt_state_t;

	localparam hlt_state_t HLT_STATE_RESET = '{cnt: HLT_COUNT_RESET,
		period: HLT_PERIOD_RESET, default: '0};

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} hlt_sync_state_t;
endpackage

// file: hdl/hlt_ers_if.sv
/*
 * Carrier for the filtered external reset level between the pin synchroniser
 * and the timer core. Both ends sit on clk_sys.
 */
`timescale 1ns/1ps
interface hlt_ers_if;
	logic level;
	modport src (output level);
	modport sink (input level);
endinterface

// file: hdl/hlt_pin_sync.sv
/*
 * Three-flop synchroniser with agreement filter for the external reset pin.
 * Assumes the pin is asynchronous to clk_sys; output changes once flops two and three agree.
 */
`timescale 1ns/1ps
module hlt_pin_sync
	import hlt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic pin_in,
	hlt_ers_if.src ers
);
	hlt_sync_state_t s;
	hlt_sync_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.s1 = pin_in;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		if (s.s2 == s.s3) begin
			next_s.level = s.s3;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign ers.level = s.level;
endmodule // hlt_pin_sync

// file: dv/hlt_trig_src.sv
/*
 * trigger source model driving the timer's external reset input.
 * assumes clk_sys clocks it and the timer runs at prescale 1:1.
 */
`timescale 1ns/1ps
module hlt_trig_src (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic want,
	output logic ext_reset_signal
);
	logic [3:0] gap;
	////////////////////////////////////////////////////////////
	// follow requested level, changes kept apart
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_reset_signal <= 1'b0;
			gap <= 4'h0;
		end else if (gap != 4'h0) begin
			gap <= gap - 4'h1;
		end else if (want != ext_reset_signal) begin
			ext_reset_signal <= want;
			gap <= 4'h8;
		end
	end
endmodule // hlt_trig_src

// file: dv/tb_top.sv
/*
 * self-checking bench for the hardware-limit period timer.
 * assumes prescale 1:1, trigger model on the external input, plain register port.
 */
`timescale 1ns/1ps
module tb_top;
	import hlt_pkg::*;
	logic clk_sys, rst_n, reg_wr, reg_rd, want;
	logic [2:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, count_value, period_value, d;
	logic postscaled_pulse, timer_irq, ext_reset_signal, lastp;
	int failures = 0, checked = 0, seed = 32'hfa376bef;
	int per, os, prev, ex, wraps, pulses, c, i;
	logic [4:0] ems [3] = '{HLT_M_OS_RISE, HLT_M_OS_FALL, HLT_M_OS_ANY};
	logic [4:0] rsv [4] = '{5'h10, 5'h14, 5'h18, 5'h1f};
	hlt_timer #(.RESTART_TICKS(2)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ext_reset_signal(ext_reset_signal),
		.count_value(count_value), .period_value(period_value),
		.postscaled_pulse(postscaled_pulse), .timer_irq(timer_irq));
	hlt_trig_src u_src (.clk_sys(clk_sys), .rst_n(rst_n), .want(want),
		.ext_reset_signal(ext_reset_signal));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////
	// reporting
	task automatic give_verdict;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	////////////////////////////////////////////////////////////
	// bus and wait helpers
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wait_cnt(input logic nz);
		int k;
		k = 0;
		while ((count_value != 8'h00) !== nz) begin
			@(posedge clk_sys);
			#1 k++;
			if (k > 400) begin
				failures++;
				$display("FAIL t=%0t got=%h exp=%h", $time, count_value, nz);
				give_verdict();
			end
		end
	endtask
	task automatic run(input logic [4:0] m, input logic [7:0] p, input logic [7:0] ctl);
		wr(HLT_ADDR_MODE, {3'h0, m});
		wr(HLT_ADDR_PERIOD, p);
		wr(HLT_ADDR_COUNT, 8'h00);
		wr(HLT_ADDR_CTRL, ctl);
	endtask
	////////////////////////////////////////////////////////////
	// scenarios
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		want = 1'b0;
		lastp = 1'b0;
		idle(4);
		rst_n <= 1'b1;
		for (i = 5; i < 8; i++) wr(i[2:0], 8'h5a);
		for (i = 0; i < 8; i++) begin
			rd(i[2:0], d);
			chk(d, (i == 1) ? HLT_PERIOD_RESET : 8'h00);
		end
		// free-running period with random period and postscale
		per = 3 + ($random(seed) & 7);
		os = $random(seed) & 3;
		wr(HLT_ADDR_IRQ, 8'h02);
		run(HLT_M_SW_GATE, per[7:0], {4'h8, os[3:0]});
		wait_cnt(1'b1);
		chk(period_value, per[7:0]);
		prev = count_value;
		wraps = 0;
		pulses = 0;
		repeat ((per + 1) * (os + 1) * 4) begin
			@(posedge clk_sys);
			#1 ex = (prev == per) ? 0 : prev + 1;
			chk(count_value, ex[7:0]);
			chk(postscaled_pulse & lastp, 1'b0);
			lastp = postscaled_pulse;
			if (postscaled_pulse === 1'b1) pulses++;
			if (ex == 0) wraps++;
			prev = count_value;
		end
		chk(pulses >= wraps / (os + 1) - 1 && pulses <= wraps / (os + 1) + 1, 1'b1);
		chk(timer_irq, 1'b1);
		wr(HLT_ADDR_CTRL, 8'h00);
		idle(4);
		c = count_value;
		idle(10);
		chk(count_value, c[7:0]);
		wr(HLT_ADDR_IRQ, 8'h00);
		idle(2);
		chk(timer_irq, 1'b0);
		rd(HLT_ADDR_IRQ, d);
		chk(d, 8'h01);
		wr(HLT_ADDR_IRQ, 8'h03);
		rd(HLT_ADDR_IRQ, d);
		chk(d, 8'h02);
		// software one-shot with pause
		run(HLT_M_OS_SW, 8'h28, 8'h80);
		wait_cnt(1'b1);
		wr(HLT_ADDR_CTRL, 8'h00);
		idle(4);
		c = count_value;
		idle(10);
		chk(count_value, c[7:0]);
		wr(HLT_ADDR_CTRL, 8'h80);
		wait_cnt(1'b0);
		rd(HLT_ADDR_CTRL, d);
		chk(d[7], 1'b0);
		idle(10);
		chk(count_value, 8'h00);
		// edge-started one-shots
		for (i = 0; i < 3; i++) begin
			want <= (i == 1);
			idle(12);
			run(ems[i], 8'h06, 8'h80);
			idle(15);
			chk(count_value, 8'h00);
			want <= (i != 1);
			wait_cnt(1'b1);
			wait_cnt(1'b0);
			rd(HLT_ADDR_CTRL, d);
			chk(d[7], 1'b0);
			wr(HLT_ADDR_CTRL, 8'h80);
			idle(20);
			chk(count_value, 8'h00);
			wr(HLT_ADDR_CTRL, 8'h00);
		end
		// monostable rising start
		want <= 1'b0;
		idle(12);
		run(HLT_M_MS_RISE, 8'h05, 8'h80);
		want <= 1'b1;
		wait_cnt(1'b1);
		wait_cnt(1'b0);
		idle(10);
		chk(count_value, 8'h00);
		rd(HLT_ADDR_CTRL, d);
		chk(d[7], 1'b1);
		want <= 1'b0;
		idle(12);
		want <= 1'b1;
		wait_cnt(1'b1);
		// hardware gate, active high
		want <= 1'b0;
		idle(12);
		run(HLT_M_GATE_HI, 8'hc8, 8'h80);
		idle(20);
		chk(count_value, 8'h00);
		want <= 1'b1;
		wait_cnt(1'b1);
		want <= 1'b0;
		idle(12);
		c = count_value;
		idle(10);
		chk(count_value, c[7:0]);
		// high level reset
		run(HLT_M_RST_HIGH, 8'hc8, 8'h80);
		wait_cnt(1'b1);
		want <= 1'b1;
		idle(12);
		chk(count_value, 8'h00);
		want <= 1'b0;
		wait_cnt(1'b1);
		wr(HLT_ADDR_CTRL, 8'h00);
		idle(4);
		c = count_value;
		want <= 1'b1;
		idle(12);
		chk(count_value, c[7:0]);
		want <= 1'b0;
		idle(12);
		// rising edge reset
		run(HLT_M_RST_RISE, 8'hfa, 8'h80);
		wait_cnt(1'b1);
		idle(30);
		want <= 1'b1;
		idle(12);
		chk(count_value < 8'h0a, 1'b1);
		// edge start, later edges reset
		want <= 1'b0;
		idle(12);
		run(HLT_M_OS_RISE_RST, 8'h30, 8'h80);
		idle(15);
		chk(count_value, 8'h00);
		want <= 1'b1;
		wait_cnt(1'b1);
		want <= 1'b0;
		idle(12);
		want <= 1'b1;
		idle(10);
		chk(count_value < 8'h06, 1'b1);
		wait_cnt(1'b0);
		rd(HLT_ADDR_CTRL, d);
		chk(d[7], 1'b0);
		// low reset level, start on rise
		want <= 1'b0;
		idle(12);
		run(HLT_M_OS_LOWRST, 8'h08, 8'h80);
		idle(15);
		chk(count_value, 8'h00);
		want <= 1'b1;
		wait_cnt(1'b1);
		wait_cnt(1'b0);
		wr(HLT_ADDR_CTRL, 8'h80);
		idle(20);
		chk(count_value, 8'h00);
		// level one-shot, low reset level
		run(HLT_M_LVL_LOW, 8'h08, 8'h80);
		wait_cnt(1'b1);
		wait_cnt(1'b0);
		rd(HLT_ADDR_CTRL, d);
		chk(d[7], 1'b0);
		want <= 1'b0;
		idle(12);
		wr(HLT_ADDR_CTRL, 8'h80);
		idle(15);
		chk(count_value, 8'h00);
		want <= 1'b1;
		wait_cnt(1'b1);
		// reserved codes
		for (i = 0; i < 4; i++) begin
			run(rsv[i], 8'h03, 8'h80);
			wr(HLT_ADDR_IRQ, 8'h03);
			idle(30);
			chk(count_value, 8'h00);
			chk(timer_irq, 1'b0);
		end
		give_verdict();
	end
endmodule // tb_top
